// >>> udi_pkg.sv
// Purpose: shared constants for the usb device interrupt flag block
// Assumes: 10 MHz pclk, apb word registers
// Notes:   offsets and layout used by the flag block and its bench
package udi_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_MODULE_VERSION = 8'h00;
  localparam logic [7:0] OFS_EVENT_FLAGS    = 8'h04;
  localparam logic [7:0] OFS_EVENT_ENABLES  = 8'h08;
  localparam logic [7:0] OFS_FAULT_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_FAULT_ENABLES  = 8'h10;
  localparam logic [7:0] OFS_XFER_STATUS    = 8'h14;

  // ------------------------------------------------------------------
  // event bit positions
  // ------------------------------------------------------------------
  localparam int BIT_HALT   = 7;
  localparam int BIT_WAKEUP = 5;
  localparam int BIT_IDLE   = 4;
  localparam int BIT_XFER   = 3;
  localparam int BIT_FRAME  = 2;
  localparam int BIT_FAULT  = 1;
  localparam int BIT_BUSRST = 0;

  // implemented bits; bit 6 unused
  localparam logic [7:0] EVENT_MASK        = 8'hbf;
  localparam logic [7:0] FAULT_MASK        = 8'hbf;
  localparam logic [7:0] EVENT_FLAGS_RST   = 8'h00;
  localparam logic [7:0] EVENT_ENABLES_RST = 8'h00;
  localparam logic [7:0] FAULT_RST         = 8'h00;
  localparam logic [7:0] XFER_STATUS_RST   = 8'h00;

  // arbitrary revision value
  localparam logic [7:0] MODULE_REV_DEFAULT = 8'h11;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int KSTATE_NS     = 2500;
  localparam int BUSRST_NS     = 2500;
  localparam int WAKE_DELAY_NS = 2500;
  localparam int IDLE_US       = 3000;
  localparam int KSTATE_CYC    = (KSTATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BUSRST_CYC    = (BUSRST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAKE_DELAY_CYC = (WAKE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int IDLE_CYC      = IDLE_US * (CLK_HZ / 1_000_000);

  // ------------------------------------------------------------------
  // line state decode
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_J   = 2'b10,
    LS_K   = 2'b01,
    LS_SE1 = 2'b11
  } udi_line_t;

  function automatic udi_line_t udi_decode(input logic dp, input logic dm);
    udi_decode = udi_line_t'({dp, dm});
  endfunction : udi_decode

endpackage : udi_pkg

// >>> udi_tmr_if.sv
`timescale 1ns/1ps
// Purpose: carrier between flag core and line timer
// Assumes: single clock
// Notes:   timer reports qualified bus events
interface udi_tmr_if;
  logic line_k;
  logic line_se0;
  logic line_active;
  logic k_seen;
  logic busrst_seen;
  logic idle_seen;
  modport core  (input k_seen, busrst_seen, idle_seen,
                 output line_k, line_se0, line_active);
  modport timer (output k_seen, busrst_seen, idle_seen,
                 input line_k, line_se0, line_active);
endinterface : udi_tmr_if

// >>> udi_line_timer.sv
`timescale 1ns/1ps
// Purpose: times k-state, reset and idle on the bus lines
// Assumes: line inputs already synchronised
// Notes:   one-cycle pulses on qualified events
module udi_line_timer
  import udi_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // carrier
  udi_tmr_if.timer  tm
);

  logic [15:0] k_cnt;
  logic [15:0] r_cnt;
  logic [31:0] i_cnt;
  logic        r_done;

  // ------------------------------------------------------------------
  // k-state persistence
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_cnt     <= 16'h0000;
      tm.k_seen <= 1'b0;
    end else if (clk_en) begin
      tm.k_seen <= 1'b0;
      if (!tm.line_k) begin
        k_cnt <= 16'h0000;
      end else if (k_cnt < 16'(KSTATE_CYC)) begin
        k_cnt <= k_cnt + 16'h0001;
        tm.k_seen <= (k_cnt == 16'(KSTATE_CYC - 1));
      end
    end
  end

  // ------------------------------------------------------------------
  // bus reset, once per assertion
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_cnt          <= 16'h0000;
      r_done         <= 1'b0;
      tm.busrst_seen <= 1'b0;
    end else if (clk_en) begin
      tm.busrst_seen <= 1'b0;
      if (!tm.line_se0) begin
        r_cnt  <= 16'h0000;
        r_done <= 1'b0;
      end else if (!r_done) begin
        r_cnt <= r_cnt + 16'h0001;
        if (r_cnt == 16'(BUSRST_CYC - 1)) begin
          r_done         <= 1'b1;
          tm.busrst_seen <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // idle timer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_cnt        <= 32'h0000_0000;
      tm.idle_seen <= 1'b0;
    end else if (clk_en) begin
      tm.idle_seen <= 1'b0;
      if (tm.line_active) begin
        i_cnt <= 32'h0000_0000;
      end else if (i_cnt < 32'(IDLE_CYCLES)) begin
        i_cnt <= i_cnt + 32'h0000_0001;
        tm.idle_seen <= (i_cnt == 32'(IDLE_CYCLES - 1));
      end
    end
  end

endmodule : udi_line_timer

// >>> udi_flags.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Purpose: usb device event flags, enables and interrupt request
// Assumes: apb slave, 10 MHz pclk, async bus lines
// Notes:   zero wait state apb, pslverr on unmapped address
module udi_flags
  import udi_pkg::*;
#(
  parameter int         IDLE_CYCLES = IDLE_CYC,
  parameter logic [7:0] MODULE_REV  = MODULE_REV_DEFAULT
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // bus lines, async
  input  wire logic        data_plus_line,
  input  wire logic        data_minus_line,
  // serial interface engine events, same clock
  input  wire logic        halt_sent,
  input  wire logic        xfer_done,
  input  wire logic [7:0]  xfer_status_in,
  input  wire logic        frame_start_rx,
  input  wire logic [7:0]  fault_events,
  input  wire logic        clocks_restarted,
  // interrupt
  output logic             irq
);

  logic [1:0]  dp_sync;
  logic [1:0]  dm_sync;
  udi_line_t   line;
  logic [7:0]  event_flags;
  logic [7:0]  event_enables;
  logic [7:0]  fault_status_register;
  logic [7:0]  fault_enables;
  logic [7:0]  xfer_status;
  logic [7:0]  xfer_hold;
  logic        hold_valid;
  logic        wake_pend;
  logic [15:0] wake_cnt;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [7:0]  w1c;
  logic        fault_any;
  logic [7:0]  set_ev;

  udi_tmr_if tm ();

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_sync <= 2'b11;
      dm_sync <= 2'b00;
    end else if (clk_en) begin
      dp_sync <= {dp_sync[0], data_plus_line};
      dm_sync <= {dm_sync[0], data_minus_line};
    end
  end

  assign line           = udi_decode(dp_sync[1], dm_sync[1]);
  assign tm.line_k      = (line == LS_K);
  assign tm.line_se0    = (line == LS_SE0);
  assign tm.line_active = (line != LS_J);

  udi_line_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tm      (tm)
  );

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && penable && !pwrite && clk_en;
  assign hit    = (paddr == OFS_MODULE_VERSION) || (paddr == OFS_EVENT_FLAGS) ||
                  (paddr == OFS_EVENT_ENABLES)  || (paddr == OFS_FAULT_STATUS) ||
                  (paddr == OFS_FAULT_ENABLES)  || (paddr == OFS_XFER_STATUS);

  function automatic logic [7:0] w1c_mask(input logic [7:0] a, input logic [7:0] ofs,
                                          input logic [31:0] d, input logic s);
    w1c_mask = (a == ofs && s) ? d[7:0] : 8'h00;
  endfunction : w1c_mask

  assign w1c = w1c_mask(paddr, OFS_EVENT_FLAGS, pwdata, wr_acc && pstrb[0]) & EVENT_MASK;

  // ------------------------------------------------------------------
  // resume delay after clock restart
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend <= 1'b0;
      wake_cnt  <= 16'h0000;
    end else if (clk_en) begin
      if (tm.k_seen && clocks_restarted) begin
        wake_pend <= 1'b1;
        wake_cnt  <= 16'h0000;
      end else if (wake_pend) begin
        wake_cnt <= wake_cnt + 16'h0001;
        if (wake_cnt == 16'(WAKE_DELAY_CYC - 1)) begin
          wake_pend <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // fault status, error enables
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status_register <= FAULT_RST;
    end else if (clk_en) begin
      fault_status_register <= (fault_status_register &
                                ~w1c_mask(paddr, OFS_FAULT_STATUS, pwdata,
                                          wr_acc && pstrb[0]) |
                                fault_events) & FAULT_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_enables <= FAULT_RST;
    end else if (wr_acc && pstrb[0] && paddr == OFS_FAULT_ENABLES) begin
      fault_enables <= pwdata[7:0] & FAULT_MASK;
    end
  end

  assign fault_any = |(fault_status_register & fault_enables);

  // ------------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------------
  always_comb begin
    set_ev            = 8'h00;
    set_ev[BIT_HALT]  = halt_sent;
    set_ev[BIT_WAKEUP] = wake_pend && (wake_cnt == 16'(WAKE_DELAY_CYC - 1));
    set_ev[BIT_IDLE]  = tm.idle_seen;
    set_ev[BIT_XFER]  = xfer_done;
    set_ev[BIT_FRAME] = frame_start_rx;
    set_ev[BIT_FAULT] = fault_any;
    set_ev[BIT_BUSRST] = tm.busrst_seen;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags <= EVENT_FLAGS_RST;
    end else if (clk_en) begin
      event_flags <= ((event_flags & ~w1c) | set_ev) & EVENT_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_enables <= EVENT_ENABLES_RST;
    end else if (wr_acc && pstrb[0] && paddr == OFS_EVENT_ENABLES) begin
      event_enables <= pwdata[7:0] & EVENT_MASK;
    end
  end

  // ------------------------------------------------------------------
  // transfer status and holding stage
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_status <= XFER_STATUS_RST;
      xfer_hold   <= XFER_STATUS_RST;
      hold_valid  <= 1'b0;
    end else if (clk_en) begin
      if (w1c[BIT_XFER]) begin
        xfer_status <= hold_valid ? xfer_hold : XFER_STATUS_RST;
        hold_valid  <= xfer_done;
        xfer_hold   <= xfer_status_in;
      end else if (xfer_done) begin
        xfer_hold  <= xfer_status_in;
        hold_valid <= 1'b1;
        if (!event_flags[BIT_XFER] && !hold_valid) begin
          xfer_status <= xfer_status_in;
          hold_valid  <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(((event_flags & ~w1c) | set_ev) & event_enables & EVENT_MASK);
    end
  end

  // ------------------------------------------------------------------
  // apb read and response
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFS_MODULE_VERSION: prdata <= {24'h000000, MODULE_REV};
          OFS_EVENT_FLAGS:    prdata <= {24'h000000, event_flags};
          OFS_EVENT_ENABLES:  prdata <= {24'h000000, event_enables};
          OFS_FAULT_STATUS:   prdata <= {24'h000000, fault_status_register};
          OFS_FAULT_ENABLES:  prdata <= {24'h000000, fault_enables};
          OFS_XFER_STATUS:    prdata <= {24'h000000, xfer_status};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> irq == |(event_flags & $past(event_enables));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && event_flags[BIT_HALT] && !w1c[BIT_HALT]) |=> event_flags[BIT_HALT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without w1c");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && w1c[BIT_FRAME] && !frame_start_rx) |=> !event_flags[BIT_FRAME];
  endproperty
  a_clear: assert property (p_clear) else $error("w1c failed");

  property p_bit6;
    @(posedge pclk) disable iff (!presetn)
    !event_flags[6] && !event_enables[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 set");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && halt_sent) |=> event_flags[BIT_HALT];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag missed");

  property p_frame;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && frame_start_rx) |=> event_flags[BIT_FRAME];
  endproperty
  a_frame: assert property (p_frame) else $error("frame flag missed");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && fault_any) |=> event_flags[BIT_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag missed");

  property p_xfer;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && xfer_done) |=> event_flags[BIT_XFER];
  endproperty
  a_xfer: assert property (p_xfer) else $error("xfer flag missed");

  property p_rev;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == OFS_MODULE_VERSION)
      |=> prdata[7:0] == MODULE_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");

  c_irq:    cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_busrst: cover property (@(posedge pclk) disable iff (!presetn) tm.busrst_seen);
  c_wake:   cover property (@(posedge pclk) disable iff (!presetn) set_ev[BIT_WAKEUP]);
  c_unmap:  cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : udi_flags

// >>> udi_host_model.sv
`timescale 1ns/1ps
// Purpose: host side of the bus lines for the flag block bench
// Assumes: lines held by the host until the bench asks for another state
// Notes:   J idle, K resume, SE0 bus reset; the host drives J when idle
module udi_host_model
  import udi_pkg::*;
(
  // clock
  input  wire logic      pclk,
  // requested line state
  input  udi_line_t      line_req,
  // bus lines
  output logic           data_plus_line,
  output logic           data_minus_line
);
  // ------------------------------------------------------------------
  // line driver
  // ------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    {data_plus_line, data_minus_line} <= line_req;
  end
endmodule : udi_host_model

// >>> tb_top.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the usb device interrupt flag block
// Assumes: idle count shortened to 50 cycles
// Notes:   apb master tasks, host model on the bus lines
module tb_top
  import udi_pkg::*;
;
  localparam int IDLE_N = 50;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr, xfer_status_in, fault_events;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic        pready, pslverr, irq, dp, dm, ev;
  logic        halt_sent, xfer_done, frame_start_rx, clocks_restarted;
  udi_line_t   line_req;
  int          bad_count, checks_done, cyc;

  udi_flags #(.IDLE_CYCLES(IDLE_N), .MODULE_REV(MODULE_REV_DEFAULT)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_plus_line(dp), .data_minus_line(dm),
    .halt_sent(halt_sent), .xfer_done(xfer_done), .xfer_status_in(xfer_status_in),
    .frame_start_rx(frame_start_rx), .fault_events(fault_events),
    .clocks_restarted(clocks_restarted), .irq(irq));

  udi_host_model host_u (.pclk(pclk), .line_req(line_req),
    .data_plus_line(dp), .data_minus_line(dm));

  // ------------------------------------------------------------------
  // clock, timeout, helpers
  // ------------------------------------------------------------------
  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rv = prdata;
    ev = pslverr;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_irq(input string nm, input logic e);
    repeat (2) @(posedge pclk);
    chk(nm, {31'h0, e}, {31'h0, irq});
  endtask : chk_irq

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, exp & m}, rv & {24'h0, m});
  endtask : rdc

  task automatic pulse(input int b);
    @(posedge pclk);
    case (b)
      7: halt_sent <= 1'b1;
      3: xfer_done <= 1'b1;
      default: frame_start_rx <= 1'b1;
    endcase
    @(posedge pclk);
    {halt_sent, xfer_done, frame_start_rx} <= 3'b0;
  endtask : pulse

  task automatic idle_for(input udi_line_t s, input int n);
    @(posedge pclk);
    line_req <= s;
    repeat (n) @(posedge pclk);
  endtask : idle_for

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rdc("version", OFS_MODULE_VERSION, 8'hff, MODULE_REV_DEFAULT);
    chk("rdata hi", 32'h0, rv & 32'hffff_ff00);
    chk("mapped err", 32'h0, {31'h0, ev});
    rdc("flags rst", OFS_EVENT_FLAGS, 8'hef, 8'h00);
    rdc("enables rst", OFS_EVENT_ENABLES, 8'hff, 8'h00);
    apb(1'b1, OFS_MODULE_VERSION, 32'hff);
    rdc("version wr", OFS_MODULE_VERSION, 8'hff, MODULE_REV_DEFAULT);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, ev});
    apb(1'b1, OFS_EVENT_ENABLES, 32'hff);
    rdc("enables bit6", OFS_EVENT_ENABLES, 8'hff, 8'hbf);
    rdc("flags bit6", OFS_EVENT_FLAGS, 8'h40, 8'h00);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h0);
  endtask : t_reset

  task automatic t_freeze();
    @(posedge pclk) clk_en <= 1'b0;
    pulse(7);
    @(posedge pclk) clk_en <= 1'b1;
    rdc("freeze", OFS_EVENT_FLAGS, 8'h80, 8'h00);
  endtask : t_freeze

  task automatic t_events();
    int bl[3] = '{7, 3, 2};
    foreach (bl[i]) begin
      pulse(bl[i]);
      rdc("flag set", OFS_EVENT_FLAGS, 8'h1 << bl[i], 8'hff);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_EVENT_ENABLES, 32'h1 << bl[i]);
      chk_irq("irq enabled", 1'b1);
      apb(1'b1, OFS_EVENT_FLAGS, 32'h0);
      rdc("flag kept", OFS_EVENT_FLAGS, 8'h1 << bl[i], 8'hff);
      apb(1'b1, OFS_EVENT_FLAGS, 32'h1 << bl[i]);
      rdc("flag clr", OFS_EVENT_FLAGS, 8'h1 << bl[i], 8'h00);
      chk_irq("irq clr", 1'b0);
      apb(1'b1, OFS_EVENT_ENABLES, 32'h0);
    end
  endtask : t_events

  task automatic t_fault();
    @(posedge pclk) fault_events <= 8'h80;
    @(posedge pclk) fault_events <= 8'h00;
    rdc("fault masked", OFS_EVENT_FLAGS, 8'h02, 8'h00);
    apb(1'b1, OFS_FAULT_STATUS, 32'hff);
    apb(1'b1, OFS_FAULT_ENABLES, 32'h01);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h02);
    @(posedge pclk) fault_events <= 8'h01;
    @(posedge pclk) fault_events <= 8'h00;
    rdc("fault flag", OFS_EVENT_FLAGS, 8'h02, 8'h02);
    chk("fault irq", 32'h1, {31'h0, irq});
    rdc("fault status", OFS_FAULT_STATUS, 8'hff, 8'h01);
    apb(1'b1, OFS_FAULT_STATUS, 32'h01);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h02);
    rdc("fault clr", OFS_EVENT_FLAGS, 8'h02, 8'h00);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h0);
  endtask : t_fault

  task automatic t_busrst();
    idle_for(LS_SE0, 20);
    rdc("rst early", OFS_EVENT_FLAGS, 8'h01, 8'h00);
    repeat (10) @(posedge pclk);
    rdc("rst set", OFS_EVENT_FLAGS, 8'h01, 8'h01);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h01);
    repeat (40) @(posedge pclk);
    rdc("rst no rearm", OFS_EVENT_FLAGS, 8'h01, 8'h00);
    idle_for(LS_J, 5);
    idle_for(LS_SE0, 32);
    rdc("rst again", OFS_EVENT_FLAGS, 8'h01, 8'h01);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h01);
  endtask : t_busrst

  task automatic t_idle();
    idle_for(LS_K, 3);
    idle_for(LS_J, 1);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h10);
    repeat (25) @(posedge pclk);
    rdc("idle early", OFS_EVENT_FLAGS, 8'h10, 8'h00);
    idle_for(LS_K, 3);
    idle_for(LS_J, 35);
    rdc("idle restart", OFS_EVENT_FLAGS, 8'h10, 8'h00);
    repeat (30) @(posedge pclk);
    rdc("idle set", OFS_EVENT_FLAGS, 8'h10, 8'h10);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h20);
  endtask : t_idle

  task automatic t_resume();
    @(posedge pclk) clocks_restarted <= 1'b1;
    idle_for(LS_K, 40);
    rdc("resume early", OFS_EVENT_FLAGS, 8'h20, 8'h00);
    repeat (25) @(posedge pclk);
    rdc("resume set", OFS_EVENT_FLAGS, 8'h20, 8'h20);
    chk("resume irq", 32'h1, {31'h0, irq});
    @(posedge pclk) clocks_restarted <= 1'b0;
    idle_for(LS_J, 2);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h30);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h0);
  endtask : t_resume

  task automatic t_xfer();
    @(posedge pclk) xfer_status_in <= 8'h5a;
    pulse(3);
    @(posedge pclk) xfer_status_in <= 8'h3c;
    pulse(3);
    rdc("status first", OFS_XFER_STATUS, 8'hff, 8'h5a);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h08);
    rdc("status next", OFS_XFER_STATUS, 8'hff, 8'h3c);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h08);
    rdc("status empty", OFS_XFER_STATUS, 8'hff, 8'h00);
  endtask : t_xfer

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hf;
    halt_sent = 1'b0; xfer_done = 1'b0; frame_start_rx = 1'b0;
    clocks_restarted = 1'b0; xfer_status_in = 8'h00; fault_events = 8'h00;
    line_req = LS_J; bad_count = 0; checks_done = 0; cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_freeze();
    t_events();
    t_fault();
    t_busrst();
    t_idle();
    t_resume();
    t_xfer();
    wrap_up();
  end
endmodule : tb_top
